// ---- core/fse_pkg.sv ----
// constants and types for the arithmetic status and exception unit
// assumes one clock (mclk) and a datapath that reports one result per op
package fse_pkg;
	// status word bit positions
	localparam int ERR_BIT = 15;
	localparam int GDIS_BIT = 14;
	localparam int UNDEF_EN_BIT = 11;
	localparam int UNF_EN_BIT = 10;
	localparam int OVF_EN_BIT = 9;
	localparam int CONV_EN_BIT = 8;
	localparam int DBL_BIT = 7;
	localparam int LONG_BIT = 6;
	localparam int TRUNC_BIT = 5;
	localparam int MAINT_BIT = 4;
	localparam int NEG_BIT = 3;
	localparam int ZERO_BIT = 2;
	localparam int OVF_BIT = 1;
	localparam int CARRY_BIT = 0;
	// reset value and the bits software may load (maint handled apart)
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] LOAD_MASK = 16'h4FE0;
	// exception codes
	localparam logic [3:0] CODE_ILLEGAL = 4'h2;
	localparam logic [3:0] CODE_DIVZERO = 4'h4;
	localparam logic [3:0] CODE_CONV = 4'h6;
	localparam logic [3:0] CODE_OVF = 4'h8;
	localparam logic [3:0] CODE_UNF = 4'hA;
	localparam logic [3:0] CODE_UNDEF = 4'hC;
	localparam logic [3:0] CODE_MAINT = 4'hE;
	localparam logic [3:0] CODE_RST = 4'h0;
	// shared vector, 244 octal
	localparam logic [8:0] IRQ_VECTOR = 9'h0A4;
	// operand high word: sign and biased exponent fields
	localparam int SIGN_BIT = 15;
	localparam int EXP_HI = 14;
	localparam int EXP_LO = 7;
	localparam logic [7:0] EXP_ZERO = 8'h00;
	localparam logic [2:0] MODE_DIRECT_ACC = 3'h0;
	// interrupt handshake states
	typedef enum logic [1:0] {
		IRQ_IDLE = 2'b01,
		IRQ_PEND = 2'b10
	} fse_irq_state_t;
	// whole state of the main unit
	typedef struct packed {
		logic [15:0] status;
		logic [3:0] code;
		logic [15:0] addr;
		fse_irq_state_t irqState;
		logic [8:0] vector;
		logic resValid;
		logic resWrite;
		logic resForceZero;
		logic [7:0] resExp;
		logic [31:0] convOut;
	} fse_state_t;
endpackage : fse_pkg

// ---- core/fse_exp_fixup.sv ----
// exponent range check and result fixup for one arithmetic result
// assumes a 10-bit two's complement biased exponent from the datapath
`timescale 1ns/1ps
module fse_exp_fixup (
	input wire logic [9:0] expFull,
	input wire logic resIsZero,
	input wire logic unfEn,
	input wire logic ovfEn,
	input wire logic lateVariant,
	output logic ovf,
	output logic unf,
	output logic forceZero,
	output logic [7:0] expOut
);
	// ovf: positive and beyond 8 bits; unf: at or below zero bias
	always_comb begin
		ovf = !expFull[9] && expFull[8];
		unf = !resIsZero && (expFull[9] || expFull == 10'h000);
		// low eight bits are the wrapped exponent, off by 400 octal
		expOut = expFull[7:0];
		// disabled underflow is zeroed on both variants
		// disabled overflow is zeroed on the late variant only
		forceZero = (unf && !unfEn) || (ovf && !ovfEn && lateVariant);
	end
endmodule : fse_exp_fixup

// ---- core/fse_int_range.sv ----
// range check of a float to integer conversion result
// assumes the datapath hands over the full signed integer before cut
`timescale 1ns/1ps
module fse_int_range (
	input wire logic signed [33:0] value,
	input wire logic longSel,
	output logic fail,
	output logic carry,
	output logic [31:0] intOut
);
	logic fitsLong; // sign bits above bit 31 agree
	logic fitsShort; // sign bits above bit 15 agree
	always_comb begin
		fitsLong = (value[33:31] == {3{value[31]}});
		fitsShort = (value[33:15] == {19{value[15]}});
		// word width picked by the long select
		fail = longSel ? !fitsLong : !fitsShort;
		// carry out of the top bit only happens when it does not fit
		carry = fail;
		// failed conversion stores zero
		if (fail) begin
			intOut = 32'h0000_0000;
		end else if (longSel) begin
			intOut = value[31:0];
		end else begin
			intOut = {{16{value[15]}}, value[15:0]};
		end
	end
endmodule : fse_int_range

// ---- core/fse_status_unit.sv ----
// status word, exception code/address and interrupt request
// assumes datapath strobes opDone once per instruction, on mclk
`timescale 1ns/1ps
module fse_status_unit (
	input wire logic mclk,
	input wire logic rst_n,
	// reset instruction from the central processor
	input wire logic sysResetInstr,
	// load status instruction and its word
	input wire logic loadStatus,
	input wire logic [15:0] loadData,
	input wire logic kernelMode,
	// one instruction finished or trapped
	input wire logic opDone,
	input wire logic [15:0] opAddr,
	input wire logic opIllegal,
	input wire logic opDivZero,
	input wire logic opMaintTrap,
	input wire logic opUndefElig,
	input wire logic opNegAbs,
	input wire logic opIsConv,
	input wire logic operandFromMem,
	input wire logic [2:0] addrMode,
	input wire logic [15:0] operandHi,
	input wire logic resNeg,
	input wire logic resZeroIn,
	input wire logic [9:0] resExpFull,
	input wire logic signed [33:0] convValue,
	input wire logic lateVariant,
	// processor accepted the interrupt
	input wire logic irqAck,
	// status word as read by the store instruction
	output logic [15:0] statusWord,
	output logic [3:0] excCode,
	output logic [15:0] excAddr,
	output logic irqReq,
	output logic [8:0] irqVector,
	// result write-back controls toward the datapath
	output logic resultValid,
	output logic resultWrite,
	output logic resultForceZero,
	output logic [7:0] resultExp,
	output logic [31:0] convResult,
	// mode selects steering the datapath
	output logic dblSel,
	output logic longSel,
	output logic truncSel
);
	// synchronised reset copy
	logic rstMeta;
	logic rstSync;
	// main state and its next value
	fse_pkg::fse_state_t state_reg;
	fse_pkg::fse_state_t state_next;
	// submodule results
	logic ovf;
	logic unf;
	logic fixZero;
	logic [7:0] fixExp;
	logic convFail;
	logic convCarry;
	logic [31:0] convInt;
	// decoded conditions for this instruction
	logic undefSeen;
	logic undefBefore;
	logic undefAfter;
	logic takeAny;
	logic executed;
	logic [3:0] takeCode;
	// every check below runs on mclk and rests while reset is low
	default clocking cbChk @(posedge mclk);
	endclocking
	default disable iff (!rstSync);

	// 0 pattern: sign one, biased exponent zero
	function automatic logic isUndef(input logic [15:0] w);
		isUndef = w[fse_pkg::SIGN_BIT]
			&& (w[fse_pkg::EXP_HI:fse_pkg::EXP_LO] == fse_pkg::EXP_ZERO);
	endfunction : isUndef

	// pick a status bit, shared by many decodes
	function automatic logic stBit(input logic [15:0] s, input int idx);
		stBit = s[idx];
	endfunction : stBit

	// reset release through two flops; assert stays asynchronous
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// exponent range check and wrapped exponent
	fse_exp_fixup uFix (
		.expFull(resExpFull),
		.resIsZero(resZeroIn),
		.unfEn(stBit(state_reg.status, fse_pkg::UNF_EN_BIT)),
		.ovfEn(stBit(state_reg.status, fse_pkg::OVF_EN_BIT)),
		.lateVariant(lateVariant),
		.ovf(ovf),
		.unf(unf),
		.forceZero(fixZero),
		.expOut(fixExp)
	);

	// integer width check for conversions
	fse_int_range uConv (
		.value(convValue),
		.longSel(stBit(state_reg.status, fse_pkg::LONG_BIT)),
		.fail(convFail),
		.carry(convCarry),
		.intOut(convInt)
	);

	// exception decode and precedence
	always_comb begin
		// accumulator operands in direct mode never take the -0 trap
		undefSeen = opUndefElig && operandFromMem
			&& (addrMode != fse_pkg::MODE_DIRECT_ACC)
			&& isUndef(operandHi)
			&& stBit(state_reg.status, fse_pkg::UNDEF_EN_BIT);
		// late variant traps neg/abs after they execute
		undefAfter = undefSeen && lateVariant && opNegAbs;
		undefBefore = undefSeen && !undefAfter;
		takeAny = 1'b1;
		executed = 1'b1;
		takeCode = fse_pkg::CODE_RST;
		// first detected condition is recorded, later ones dropped
		if (opIllegal) begin
			takeCode = fse_pkg::CODE_ILLEGAL;
			executed = 1'b0;
		end else if (opMaintTrap
			&& stBit(state_reg.status, fse_pkg::MAINT_BIT)) begin
			takeCode = fse_pkg::CODE_MAINT;
			executed = 1'b0;
		end else if (undefBefore) begin
			// trap taken before execution: nothing written
			takeCode = fse_pkg::CODE_UNDEF;
			executed = 1'b0;
		end else if (opDivZero) begin
			takeCode = fse_pkg::CODE_DIVZERO;
			executed = 1'b0;
		end else if (opIsConv && convFail
			&& stBit(state_reg.status, fse_pkg::CONV_EN_BIT)) begin
			takeCode = fse_pkg::CODE_CONV;
		end else if (!opIsConv && ovf
			&& stBit(state_reg.status, fse_pkg::OVF_EN_BIT)) begin
			takeCode = fse_pkg::CODE_OVF;
		end else if (!opIsConv && unf
			&& stBit(state_reg.status, fse_pkg::UNF_EN_BIT)) begin
			takeCode = fse_pkg::CODE_UNF;
		end else if (undefAfter) begin
			takeCode = fse_pkg::CODE_UNDEF;
		end else begin
			// disabled or absent exceptions are not taken
			takeAny = 1'b0;
		end
	end

	// next state: status word, records, interrupt, write-back
	always_comb begin
		state_next = state_reg;
		state_next.resValid = 1'b0;
		// software load of modes and enables
		if (loadStatus) begin
			state_next.status = (state_reg.status & ~fse_pkg::LOAD_MASK)
				| (loadData & fse_pkg::LOAD_MASK);
			// maint mode only from kernel mode
			if (kernelMode) begin
				state_next.status[fse_pkg::MAINT_BIT] =
					loadData[fse_pkg::MAINT_BIT];
			end
			// the load and the reset instruction are the only software clears of the error flag
			// the flag is device produced, so the loaded bit is ignored
			state_next.status[fse_pkg::ERR_BIT] = 1'b0;
		end
		// reset instruction returns the word to its reset value
		if (sysResetInstr) begin
			state_next.status = fse_pkg::STATUS_RST;
		end
		if (opDone) begin
			// write-back controls for the datapath
			state_next.resValid = 1'b1;
			state_next.resWrite = executed;
			state_next.resForceZero = fixZero && !opIsConv;
			state_next.resExp = fixExp;
			state_next.convOut = convInt;
			// condition codes follow every executed operation
			if (executed) begin
				state_next.status[fse_pkg::NEG_BIT] = resNeg && !fixZero;
				state_next.status[fse_pkg::ZERO_BIT] = resZeroIn || fixZero;
				state_next.status[fse_pkg::OVF_BIT] = ovf && !opIsConv;
				state_next.status[fse_pkg::CARRY_BIT] = opIsConv && convCarry;
			end
			if (takeAny) begin
				// set wins over a load in the same cycle
				state_next.status[fse_pkg::ERR_BIT] = 1'b1;
				// record cause and faulting address
				state_next.code = takeCode;
				state_next.addr = opAddr;
			end
		end
		// interrupt handshake; global disable only blocks the request
		case (state_reg.irqState)
			fse_pkg::IRQ_IDLE: begin
				if (opDone && takeAny
					&& !stBit(state_reg.status, fse_pkg::GDIS_BIT)) begin
					state_next.irqState = fse_pkg::IRQ_PEND;
					state_next.vector = fse_pkg::IRQ_VECTOR;
				end
			end
			fse_pkg::IRQ_PEND: begin
				// held until the processor takes the vector or a reset instruction drops it
				if (irqAck || sysResetInstr) begin
					state_next.irqState = fse_pkg::IRQ_IDLE;
				end
			end
			default: begin
				state_next.irqState = fse_pkg::IRQ_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			state_reg.status <= fse_pkg::STATUS_RST;
			state_reg.code <= fse_pkg::CODE_RST;
			state_reg.addr <= 16'h0000;
			state_reg.irqState <= fse_pkg::IRQ_IDLE;
			state_reg.vector <= fse_pkg::IRQ_VECTOR;
			state_reg.resValid <= 1'b0;
			state_reg.resWrite <= 1'b0;
			state_reg.resForceZero <= 1'b0;
			state_reg.resExp <= 8'h00;
			state_reg.convOut <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state flops
	always_comb begin
		// field order of the word is fixed by the bit constants
		statusWord = state_reg.status;
		excCode = state_reg.code;
		excAddr = state_reg.addr;
		irqReq = (state_reg.irqState == fse_pkg::IRQ_PEND);
		irqVector = state_reg.vector;
		resultValid = state_reg.resValid;
		resultWrite = state_reg.resWrite;
		resultForceZero = state_reg.resForceZero;
		resultExp = state_reg.resExp;
		convResult = state_reg.convOut;
		// mode selects for precision, integer width, chop
		dblSel = state_reg.status[fse_pkg::DBL_BIT];
		longSel = state_reg.status[fse_pkg::LONG_BIT];
		truncSel = state_reg.status[fse_pkg::TRUNC_BIT];
	end

	// checks on the recorded state
	AST_ERR_SET: assert property (
		opDone && takeAny && !sysResetInstr |=> statusWord[15])
		else $error("error flag not set by taken exception");
	AST_ERR_STICKY: assert property (
		statusWord[15] && !loadStatus && !sysResetInstr |=> statusWord[15])
		else $error("error flag cleared by the unit itself");
	AST_GDIS_NOIRQ: assert property (
		!irqReq && statusWord[14] |=> !irqReq)
		else $error("interrupt raised while globally disabled");
	AST_ILLEGAL_REC: assert property (
		opDone && opIllegal |=> excCode == 4'h2 && excAddr == $past(opAddr))
		else $error("illegal opcode not recorded");
	AST_NO_UPDATE: assert property (
		opDone && !takeAny |=> $stable(excCode) && $stable(excAddr))
		else $error("records changed without a taken exception");
	AST_UNF_ZERO: assert property (
		opDone && !opIsConv && unf && !statusWord[10]
		|=> resultValid && resultForceZero)
		else $error("disabled underflow not zeroed");
	AST_CONV_FAIL: assert property (
		opDone && opIsConv && convFail && !opIllegal && !opDivZero
		&& !opMaintTrap && !undefSeen && !sysResetInstr
		|=> convResult == 32'h0000_0000 && statusWord[0])
		else $error("failed conversion not zeroed with carry");
	AST_MAINT_KERNEL: assert property (
		loadStatus && !kernelMode && !statusWord[4] |=> !statusWord[4])
		else $error("maint mode set outside kernel mode");
	AST_IRQ_VEC: assert property (
		opDone && takeAny && !irqReq && !statusWord[14]
		|=> irqReq && irqVector == 9'h0A4)
		else $error("interrupt or vector missing");
	AST_ZERO_COND: assert property (
		opDone && executed && !sysResetInstr
		|=> statusWord[2] == $past(resZeroIn || fixZero))
		else $error("zero code does not follow result");
	// divide by zero is recorded unless an earlier cause won
	AST_DIV_REC: assert property (
		opDone && opDivZero && !opIllegal && !opMaintTrap && !undefBefore
		|=> excCode == fse_pkg::CODE_DIVZERO && excAddr == $past(opAddr))
		else $error("divide by zero not recorded");
	// memory -0 trapped early leaves the result unwritten
	AST_UNDEF_EARLY: assert property (
		opDone && undefBefore && !opIllegal && !opMaintTrap
		|=> !resultWrite && excCode == fse_pkg::CODE_UNDEF)
		else $error("early undefined operand trap not taken");
	// an accumulator operand in direct mode never records a -0 trap
	AST_ACC_NOTRAP: assert property (
		opDone && addrMode == fse_pkg::MODE_DIRECT_ACC && !opIllegal
		&& !opDivZero && !opMaintTrap && !opIsConv && !ovf && !unf
		|=> $stable(excCode) && $stable(excAddr))
		else $error("direct accumulator operand recorded a trap");
	// out of range exponents keep their low eight bits, wrapped
	AST_EXP_WRAP: assert property (
		opDone && !opIsConv && (ovf || unf)
		|=> resultExp == 8'($past(resExpFull)))
		else $error("wrapped exponent not handed over");
	// disabled overflow: zero on the late variant, wrapped on the early
	AST_OVF_VARIANT: assert property (
		opDone && !opIsConv && ovf && !statusWord[fse_pkg::OVF_EN_BIT]
		|=> resultForceZero == $past(lateVariant))
		else $error("disabled overflow result wrong for variant");
	// carry code is cleared by every executed non conversion op
	AST_CARRY_CLR: assert property (
		opDone && executed && !opIsConv && !sysResetInstr
		|=> !statusWord[fse_pkg::CARRY_BIT])
		else $error("carry code not cleared");
	// a request stands until the processor takes it or a reset instruction drops it
	AST_IRQ_HOLD: assert property (
		irqReq && !irqAck && !sysResetInstr |=> irqReq)
		else $error("interrupt request dropped without ack");
	// reset instruction clears the word and drops the request
	AST_RST_INSTR: assert property (
		sysResetInstr && !opDone
		|=> statusWord == fse_pkg::STATUS_RST && !irqReq)
		else $error("reset instruction left status or request");
	// a load clears the error flag and keeps the condition codes
	AST_LOAD_KEEP: assert property (
		loadStatus && !opDone && !sysResetInstr
		|=> !statusWord[fse_pkg::ERR_BIT]
		&& $stable(statusWord[fse_pkg::NEG_BIT:fse_pkg::CARRY_BIT]))
		else $error("load touched error flag or condition codes");
	// a long conversion that fits hands over the whole integer
	AST_CONV_LONG: assert property (
		opDone && opIsConv && longSel && !convFail
		|=> convResult == 32'($past(convValue)))
		else $error("long conversion result not passed");
endmodule : fse_status_unit

// ---- tb/fse_cpu_model.sv ----
// interrupt side of the central processor: takes the request, acks later
// assumes one mclk domain; the bench picks the acknowledge delay
`timescale 1ns/1ps
module fse_cpu_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic irqReq,
	input wire logic [3:0] ackDelay,
	output logic irqAck
);
	// ack is one cycle long, a chosen number of edges after the request
	// a slow ack keeps the request standing, which the bench relies on
	initial begin
		irqAck = 1'h0;
		forever begin
			@(posedge mclk);
			if (irqReq === 1'h1 && rst_n === 1'h1) begin
				repeat (ackDelay) @(posedge mclk);
				irqAck <= 1'h1;
				@(posedge mclk);
				irqAck <= 1'h0;
				@(posedge mclk);
			end
		end
	end
endmodule : fse_cpu_model

// ---- tb/tb.sv ----
// self-checking bench for the status and exception unit
// assumes fse_pkg, the design and the cpu model are compiled first
`timescale 1ns/1ps
module tb;
	// one expected result per operation
	typedef struct {
		logic [3:0] code;
		logic [15:0] addr;
		logic [6:0] flags;
		logic [6:0] mask;
		logic irq;
		logic [7:0] exp;
		logic expOn;
		logic [31:0] conv;
		int k;
	} fse_note_t;
	logic mclk, rst_n, sysResetInstr, loadStatus, kernelMode, opDone;
	logic opIllegal, opDivZero, opMaintTrap, opUndefElig, opNegAbs;
	logic opIsConv, operandFromMem, resNeg, resZeroIn, lateVariant, irqAck;
	logic [15:0] loadData, opAddr, operandHi, statusWord, excAddr;
	logic [2:0] addrMode;
	logic [9:0] resExpFull;
	logic signed [33:0] convValue;
	logic [3:0] excCode, ackDelay;
	logic irqReq, resultValid, resultWrite, resultForceZero;
	logic [8:0] irqVector;
	logic [7:0] resultExp;
	logic [31:0] convResult;
	logic dblSel, longSel, truncSel;
	// tracked expectations of the registers
	logic [15:0] st, eAddr;
	logic [3:0] eCode, eCc;
	logic eErr;
	fse_note_t q[$];
	fse_note_t m;
	int errorCnt, cmpCount, i;
	// code per scenario kind: none, illegal, div, maint, -0, conv, ovf, unf, illegal with div
	logic [3:0] codes [9] = '{4'h0, 4'h2, 4'h4, 4'hE, 4'hC, 4'h6, 4'h8,
		4'hA, 4'h2};

	fse_status_unit u_fse_status_unit (.mclk, .rst_n, .sysResetInstr,
		.loadStatus, .loadData, .kernelMode, .opDone, .opAddr, .opIllegal,
		.opDivZero, .opMaintTrap, .opUndefElig, .opNegAbs, .opIsConv,
		.operandFromMem, .addrMode, .operandHi, .resNeg, .resZeroIn,
		.resExpFull, .convValue, .lateVariant, .irqAck, .statusWord,
		.excCode, .excAddr, .irqReq, .irqVector, .resultValid, .resultWrite,
		.resultForceZero, .resultExp, .convResult, .dblSel, .longSel,
		.truncSel);
	fse_cpu_model u_fse_cpu_model (.mclk, .rst_n, .irqReq, .ackDelay,
		.irqAck);

	// 40 MHz clock
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	// verdict and end of run
	task automatic finishTest;
		$display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finishTest

	// load status word; flag drops, codes kept, maint only from kernel
	task automatic ld(input logic [15:0] d, input logic k);
		@(negedge mclk);
		loadStatus = 1'h1;
		loadData = d;
		kernelMode = k;
		@(negedge mclk);
		loadStatus = 1'h0;
		// a load outside kernel mode keeps the maint bit as it was
		st = (d & fse_pkg::LOAD_MASK)
			| ((k ? d : st) & 16'h0010);
		eErr = 1'h0;
		chk(statusWord, {1'h0, st[14:4], eCc});
		chk({dblSel, longSel, truncSel}, st[7:5]);
	endtask : ld

	// one operation of kind k; the expected result goes on the queue
	task automatic op(input int k);
		fse_note_t n;
		logic en, nx, zr;
		int w;
		w = 0;
		// a pending interrupt would swallow the next request
		while (irqReq === 1'h1 && w < 50) begin
			@(negedge mclk);
			w++;
		end
		if (w == 50) begin
			errorCnt++;
			finishTest();
		end
		@(negedge mclk);
		opDone = 1'h1;
		opAddr = 16'($urandom);
		opIllegal = (k == 1 || k == 8);
		opDivZero = (k == 2 || k == 8);
		opMaintTrap = (k == 3);
		operandHi = (k == 4) ? {9'h100, 7'($urandom)} : 16'h4080;
		opIsConv = (k == 5);
		resNeg = (k == 0) ? 1'($urandom) : 1'h0;
		resZeroIn = (k == 0) ? 1'($urandom) : 1'h0;
		opNegAbs = (k == 4) ? 1'($urandom) : 1'h0;
		addrMode = (k == 4) ? 3'($urandom) : 3'h1;
		resExpFull = (k == 6) ? 10'h1A5 : (k == 7) ? 10'h3F0 : 10'h081;
		lateVariant = 1'($urandom);
		// -0 never traps from a direct accumulator operand
		en = (k == 1 || k == 2 || k == 8) | ((k == 3) & st[4])
			| ((k == 4) & st[11] & (addrMode != 3'h0))
			| ((k == 5) & st[8] & !st[6])
			| ((k == 6) & st[9]) | ((k == 7) & st[10]);
		// late variant traps neg/abs on -0 after executing them
		nx = (k == 1 || k == 2 || k == 8) | (en & (k == 3))
			| (en & (k == 4) & !(lateVariant & opNegAbs));
		zr = !en & ((k == 7) | ((k == 6) & lateVariant));
		if (en) begin
			eCode = codes[k];
			eAddr = opAddr;
			eErr = 1'h1;
		end
		if (!nx) begin
			eCc = {resNeg & !zr, zr | resZeroIn, k == 6, (k == 5) & !st[6]};
		end
		n.code = eCode;
		n.addr = eAddr;
		n.flags = {eErr, eCc, !nx, zr};
		n.mask = (k == 5) ? 7'h47 : 7'h7F;
		n.irq = en & !st[14];
		n.exp = resExpFull[7:0];
		n.expOn = en & (k == 6 || k == 7);
		n.conv = st[6] ? 32'h00009C40 : 32'h00000000;
		n.k = k;
		q.push_back(n);
		@(negedge mclk);
		opDone = 1'h0;
	endtask : op

	// result watcher: oldest note against each result pulse
	always @(negedge mclk) begin
		if (resultValid === 1'h1) begin
			if (q.size() == 0) begin
				chk(32'h1, 32'h0);
			end else begin
				m = q.pop_front();
				chk(excCode, m.code);
				chk(excAddr, m.addr);
				chk({statusWord[15], statusWord[3:0], resultWrite,
					resultForceZero} & m.mask,
					m.flags & m.mask);
				chk(irqReq, m.irq);
				if (m.irq) chk(irqVector, fse_pkg::IRQ_VECTOR);
				if (m.expOn) chk(resultExp, m.exp);
				if (m.k == 5) chk(convResult, m.conv);
			end
		end
	end

	// main sequence
	initial begin
		void'($urandom(85965));
		{rst_n, sysResetInstr, loadStatus, kernelMode, opDone} = 5'h00;
		{opIllegal, opDivZero, opMaintTrap, opIsConv, resNeg} = 5'h00;
		{opNegAbs, resZeroIn, lateVariant} = 3'h0;
		opUndefElig = 1'h1;
		operandFromMem = 1'h1;
		addrMode = 3'h1;
		{loadData, opAddr, operandHi} = 48'h0;
		resExpFull = 10'h081;
		convValue = 34'sh09C40;
		ackDelay = 4'h2;
		{st, eAddr, eCode, eCc, eErr} = 41'h0;
		repeat (2) @(negedge mclk);
		rst_n = 1'h1;
		repeat (3) @(negedge mclk);
		chk({statusWord, irqReq}, 32'h0);
		chk({excCode, excAddr}, 32'h0);
		chk(irqVector, fse_pkg::IRQ_VECTOR);
		// every kind, random enables, modes and ack speed
		for (i = 0; i < 72; i++) begin
			ackDelay = 4'(1 + $urandom % 4);
			ld(16'($urandom), 1'($urandom));
			op(i % 9);
			op($urandom % 9);
		end
		// reset instruction while an interrupt is pending
		ackDelay = 4'h8;
		ld(16'h0F00, 1'h1);
		op(2);
		sysResetInstr = 1'h1;
		@(negedge mclk);
		sysResetInstr = 1'h0;
		chk({statusWord, irqReq, excCode}, {17'h0, 4'h4});
		repeat (12) @(negedge mclk);
		chk(q.size(), 0);
		finishTest();
	end
endmodule : tb
